// ### tw_pkg.sv
package tw_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one aligned 32-bit word each)
    // ------------------------------------------------------------------
    localparam int unsigned TW_ADR_W     = 8;
    localparam logic [7:0]  TW_OFS_CTRL  = 8'h00;
    localparam logic [7:0]  TW_OFS_COUNT = 8'h04;
    localparam logic [7:0]  TW_OFS_CMP_A = 8'h08;
    localparam logic [7:0]  TW_OFS_CMP_B = 8'h0c;
    localparam logic [7:0]  TW_OFS_FLAGS = 8'h10;
    localparam logic [7:0]  TW_OFS_PORT  = 8'h14;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned TW_CTRL_MODE_LSB  = 0;
    localparam int unsigned TW_CTRL_COM_B_LSB = 4;
    localparam int unsigned TW_CTRL_COM_A_LSB = 6;
    localparam int unsigned TW_FLAG_OV        = 0;
    localparam int unsigned TW_FLAG_MATCH_A   = 1;
    localparam int unsigned TW_FLAG_MATCH_B   = 2;
    localparam int unsigned TW_PORT_DIR_LSB   = 0;
    localparam int unsigned TW_PORT_DATA_LSB  = 2;
    localparam int unsigned TW_PORT_WAVE_LSB  = 4;

    // ------------------------------------------------------------------
    // Counter limits and encodings
    // ------------------------------------------------------------------
    localparam logic [7:0] TW_BOTTOM       = 8'h00;
    localparam logic [7:0] TW_MAX          = 8'hff;
    localparam logic [7:0] TW_ONE          = 8'h01;
    localparam logic [2:0] TW_SEL_PC_MAX   = 3'h1;
    localparam logic [2:0] TW_SEL_CTC      = 3'h2;
    localparam logic [2:0] TW_SEL_FAST_MAX = 3'h3;
    localparam logic [2:0] TW_SEL_PC_CMP   = 3'h5;
    localparam logic [2:0] TW_SEL_FAST_CMP = 3'h7;
    localparam logic [1:0] TW_COM_OFF      = 2'h0;
    localparam logic [1:0] TW_COM_TOGGLE   = 2'h1;
    localparam logic [1:0] TW_COM_CLEAR    = 2'h2;
    localparam logic [1:0] TW_COM_SET      = 2'h3;

    typedef enum logic [1:0] {
        TW_NORMAL,
        TW_PHASE,
        TW_CLEAR_MATCH,
        TW_FAST
    } tw_mode_e;

    // Channel index 0 is channel A, 1 is channel B
    typedef struct packed {
        logic [2:0]      mode_sel;
        logic [1:0][1:0] com;
    } tw_ctrl_s;

    typedef struct packed {
        tw_ctrl_s        ctrl;
        logic [7:0]      count;
        logic            down;
        logic            block;
        logic [1:0][7:0] ocr;
        logic [1:0][7:0] ocr_buf;
        logic            ov_flag;
        logic [1:0]      match_flag;
        logic [1:0]      wave;
        logic [1:0]      up_seen;
        logic [1:0]      fix;
        logic [1:0]      pin_dir;
        logic [1:0]      port_data;
        logic [1:0]      pin_out;
        logic [1:0]      pin_oe;
        logic            ack;
        logic [31:0]     rdata;
    } tw_state_s;

    localparam tw_state_s TW_STATE_RST = '0;

endpackage : tw_pkg

// ### tw_timer_top.sv
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/1ps
// What this block does
// - Mode 0: count up only, wrap FF to 00
// - Normal: overflow flag set when count becomes zero
// - Mode select and compare A shape the count sequence
// - Mode 2: clear count on match with A
// - Mode 2: unbuffered A, missed match wraps first
// - Mode 2: match flag A set at top
// - Mode 2, toggle setting: output A toggles per match
// - Mode 2: overflow flag on max to zero
// - Modes 3 and 7: fast PWM, top FF or A
// - Fast PWM: clear count tick after reaching top
// - Fast PWM: 2 clears on match, 3 sets
// - Fast PWM: overflow flag set at top
// - PWM toggle only on A with mode bit two
// - Fast PWM: bottom compare spikes, max compare constant
// - Fast PWM: compare values double buffered
// - Modes 1 and 5: dual slope, top FF or A
// - Phase PWM: up match clears, down match sets
// - Phase PWM: top held one tick, then down
// - Phase PWM: overflow flag set at bottom
// - Phase PWM: bottom compare low, max compare high
// - Phase PWM: missed up match applied at bottom
// - Pin driven only while direction is output
// - Match flags set on the matching tick
// - Reset clears both waveform states
module tw_timer_top
    import tw_pkg::*;
(
    // Clock and reset
    input  wire logic                REF_CLK_I,
    input  wire logic                RST_N_I,
    // Prescaled timer tick from the same clock domain
    input  wire logic                TIMER_TICK_I,
    // Wishbone classic slave
    input  wire logic                WB_CYC_I,
    input  wire logic                WB_STB_I,
    input  wire logic                WB_WE_I,
    input  wire logic [TW_ADR_W-1:0] WB_ADR_I,
    input  wire logic [3:0]          WB_SEL_I,
    input  wire logic [31:0]         WB_DAT_I,
    output logic      [31:0]         WB_DAT_O,
    output logic                     WB_ACK_O,
    // Waveform pins
    output logic                     WAVE_A_PIN_O,
    output logic                     WAVE_A_OE_O,
    output logic                     WAVE_B_PIN_O,
    output logic                     WAVE_B_OE_O
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    tw_state_s  q;
    tw_state_s  d;
    tw_mode_e   mode;
    logic [7:0] top;
    logic       is_pwm;
    logic       hit;
    logic       wr;
    logic       cnt_wr;
    logic       tick;
    logic       at_top;
    logic       up_now;
    logic       ov_set;
    logic [1:0] match;
    logic [1:0] match_set;
    logic [1:0] ocr_top;
    logic [1:0] com;
    logic [7:0] rbyte;

    function automatic tw_mode_e decode_mode(input logic [2:0] sel);
        case (sel)
            TW_SEL_PC_MAX, TW_SEL_PC_CMP:     decode_mode = TW_PHASE;
            TW_SEL_CTC:                       decode_mode = TW_CLEAR_MATCH;
            TW_SEL_FAST_MAX, TW_SEL_FAST_CMP: decode_mode = TW_FAST;
            // Unused selections fall back to plain counting
            default:                          decode_mode = TW_NORMAL;
        endcase
    endfunction : decode_mode

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d         = q;
        rbyte     = '0;
        com       = '0;
        ov_set    = 1'b0;
        match_set = '0;
        mode      = decode_mode(q.ctrl.mode_sel);
        // Select bit two picks compare A as top in both PWM families
        if (mode == TW_CLEAR_MATCH || (q.ctrl.mode_sel[2] && mode != TW_NORMAL)) begin
            top = q.ocr[0];
        end else begin
            top = TW_MAX;
        end
        is_pwm = (mode == TW_PHASE) || (mode == TW_FAST);
        hit    = WB_CYC_I && WB_STB_I && !q.ack;
        wr     = hit && WB_WE_I && WB_SEL_I[0];
        cnt_wr = wr && (WB_ADR_I == TW_OFS_COUNT);
        // A software count write beats any count or clear on the same edge
        tick   = TIMER_TICK_I && !cnt_wr;
        at_top = (q.count == top);
        up_now = !q.down || (q.count == TW_BOTTOM);
        for (int i = 0; i < 2; i++) begin
            match[i]   = (q.count == q.ocr[i]) && !q.block;
            ocr_top[i] = (q.ocr[i] == top);
        end

        // --------------------------------------------------------------
        // Counter
        // --------------------------------------------------------------
        if (tick) begin
            d.block   = 1'b0;
            match_set = match;
            case (mode)
                TW_CLEAR_MATCH: begin
                    // Compare A is live here, so a value below the count is
                    // only met after the wrap through FF
                    if (match[0]) begin
                        d.count = TW_BOTTOM;
                    end else begin
                        d.count = q.count + TW_ONE;
                    end
                    ov_set = (q.count == TW_MAX);
                end
                TW_FAST: begin
                    if (at_top) begin
                        d.count = TW_BOTTOM;
                        d.ocr   = q.ocr_buf;
                        ov_set  = 1'b1;
                    end else begin
                        d.count = q.count + TW_ONE;
                    end
                end
                TW_PHASE: begin
                    if (!q.down) begin
                        if (at_top) begin
                            d.ocr = q.ocr_buf;
                            // Top has already stood one tick; now turn round
                            if (top != TW_BOTTOM) begin
                                d.down  = 1'b1;
                                d.count = q.count - TW_ONE;
                            end
                        end else begin
                            d.count = q.count + TW_ONE;
                        end
                    end else if (q.count == TW_BOTTOM) begin
                        d.down  = 1'b0;
                        d.count = q.count + TW_ONE;
                    end else begin
                        d.count = q.count - TW_ONE;
                        ov_set  = (q.count == TW_ONE);
                    end
                end
                default: begin
                    d.count = q.count + TW_ONE;
                    ov_set  = (q.count == TW_MAX);
                end
            endcase

            // ----------------------------------------------------------
            // Waveform per channel
            // ----------------------------------------------------------
            for (int i = 0; i < 2; i++) begin
                com = q.ctrl.com[i];
                case (mode)
                    TW_FAST: begin
                        if (com == TW_COM_TOGGLE) begin
                            // Buffered compare keeps the toggle period even
                            if (i == 0 && q.ctrl.mode_sel[2] && match[i]) begin
                                d.wave[i] = !q.wave[i];
                            end
                        end else if (com[1]) begin
                            if (at_top) begin
                                d.wave[i] = !com[0];
                            end else if (match[i] && !ocr_top[i]) begin
                                // Bottom compare gives a one-tick spike; a
                                // compare at top is ignored: constant level
                                d.wave[i] = com[0];
                            end
                        end
                    end
                    TW_PHASE: begin
                        if (!q.down && at_top) begin
                            d.fix[i]     = !q.up_seen[i];
                            d.up_seen[i] = 1'b0;
                        end
                        if (q.down && q.count == TW_BOTTOM) begin
                            // Restore symmetry round bottom when the up match
                            // was skipped or the compare just left top
                            if (q.fix[i] && !ocr_top[i] && com[1]) begin
                                d.wave[i] = com[0];
                            end
                            d.fix[i] = 1'b0;
                        end
                        if (com == TW_COM_TOGGLE) begin
                            if (i == 0 && q.ctrl.mode_sel[2] && match[i]) begin
                                d.wave[i] = !q.wave[i];
                            end
                        end else if (com[1]) begin
                            if (ocr_top[i]) begin
                                if (!q.down && at_top) begin
                                    d.wave[i] = !com[0];
                                end
                            end else if (match[i]) begin
                                // Bottom compare counts as an up match: low
                                d.wave[i] = up_now ? com[0] : !com[0];
                                if (up_now) begin
                                    d.up_seen[i] = 1'b1;
                                end
                            end
                        end
                    end
                    default: begin
                        if (match[i]) begin
                            case (com)
                                TW_COM_TOGGLE: d.wave[i] = !q.wave[i];
                                TW_COM_CLEAR:  d.wave[i] = 1'b0;
                                TW_COM_SET:    d.wave[i] = 1'b1;
                                default:       d.wave[i] = q.wave[i];
                            endcase
                        end
                    end
                endcase
            end
        end

        // --------------------------------------------------------------
        // Register writes
        // --------------------------------------------------------------
        if (wr) begin
            case (WB_ADR_I)
                TW_OFS_CTRL: begin
                    d.ctrl.mode_sel = WB_DAT_I[TW_CTRL_MODE_LSB +: 3];
                    d.ctrl.com[0]   = WB_DAT_I[TW_CTRL_COM_A_LSB +: 2];
                    d.ctrl.com[1]   = WB_DAT_I[TW_CTRL_COM_B_LSB +: 2];
                end
                TW_OFS_COUNT: begin
                    // Written count must not match on the next tick
                    d.count = WB_DAT_I[7:0];
                    d.block = 1'b1;
                end
                TW_OFS_CMP_A, TW_OFS_CMP_B: begin
                    d.ocr_buf[WB_ADR_I[2]] = WB_DAT_I[7:0];
                    if (!is_pwm) begin
                        d.ocr[WB_ADR_I[2]] = WB_DAT_I[7:0];
                    end
                end
                TW_OFS_PORT: begin
                    d.pin_dir   = WB_DAT_I[TW_PORT_DIR_LSB +: 2];
                    d.port_data = WB_DAT_I[TW_PORT_DATA_LSB +: 2];
                end
                default: begin
                    d.pin_dir = q.pin_dir;
                end
            endcase
        end

        // --------------------------------------------------------------
        // Flags: write one to clear, a new event wins over the clear
        // --------------------------------------------------------------
        if (wr && WB_ADR_I == TW_OFS_FLAGS) begin
            d.ov_flag       = q.ov_flag && !WB_DAT_I[TW_FLAG_OV];
            d.match_flag[0] = q.match_flag[0] && !WB_DAT_I[TW_FLAG_MATCH_A];
            d.match_flag[1] = q.match_flag[1] && !WB_DAT_I[TW_FLAG_MATCH_B];
        end
        d.ov_flag    = d.ov_flag || ov_set;
        d.match_flag = d.match_flag | match_set;

        // --------------------------------------------------------------
        // Read data and acknowledge
        // --------------------------------------------------------------
        case (WB_ADR_I)
            TW_OFS_CTRL: begin
                rbyte[TW_CTRL_MODE_LSB +: 3]  = q.ctrl.mode_sel;
                rbyte[TW_CTRL_COM_A_LSB +: 2] = q.ctrl.com[0];
                rbyte[TW_CTRL_COM_B_LSB +: 2] = q.ctrl.com[1];
            end
            TW_OFS_COUNT: rbyte = q.count;
            TW_OFS_CMP_A: rbyte = q.ocr_buf[0];
            TW_OFS_CMP_B: rbyte = q.ocr_buf[1];
            TW_OFS_FLAGS: begin
                rbyte[TW_FLAG_OV]      = q.ov_flag;
                rbyte[TW_FLAG_MATCH_A] = q.match_flag[0];
                rbyte[TW_FLAG_MATCH_B] = q.match_flag[1];
            end
            TW_OFS_PORT: begin
                rbyte[TW_PORT_DIR_LSB +: 2]  = q.pin_dir;
                rbyte[TW_PORT_DATA_LSB +: 2] = q.port_data;
                rbyte[TW_PORT_WAVE_LSB +: 2] = q.wave;
            end
            default: rbyte = '0;
        endcase
        d.ack   = hit;
        d.rdata = hit ? {24'h000000, rbyte} : 32'h00000000;

        // --------------------------------------------------------------
        // Pins: waveform overrides port data when its mode is non-zero
        // --------------------------------------------------------------
        for (int i = 0; i < 2; i++) begin
            d.pin_out[i] = (d.ctrl.com[i] != TW_COM_OFF) ? d.wave[i] : d.port_data[i];
            d.pin_oe[i]  = d.pin_dir[i];
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            q <= TW_STATE_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign WB_DAT_O     = q.rdata;
    assign WB_ACK_O     = q.ack;
    assign WAVE_A_PIN_O = q.pin_out[0];
    assign WAVE_A_OE_O  = q.pin_oe[0];
    assign WAVE_B_PIN_O = q.pin_out[1];
    assign WAVE_B_OE_O  = q.pin_oe[1];

endmodule : tw_timer_top

// ### tw_timer_top_assertions.sv
`timescale 1ns/1ps
module tw_timer_top_chk
    import tw_pkg::*;
(
    // Clock and reset
    input wire logic                REF_CLK_I,
    input wire logic                RST_N_I,
    // Timer and bus
    input wire logic                TIMER_TICK_I,
    input wire logic                WB_CYC_I,
    input wire logic                WB_STB_I,
    input wire logic                WB_WE_I,
    input wire logic [TW_ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0]          WB_SEL_I,
    input wire logic [31:0]         WB_DAT_I,
    input wire logic [31:0]         WB_DAT_O,
    input wire logic                WB_ACK_O,
    // Pins
    input wire logic                WAVE_A_PIN_O,
    input wire logic                WAVE_A_OE_O,
    input wire logic                WAVE_B_PIN_O,
    input wire logic                WAVE_B_OE_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);

    logic take;
    logic wr;
    assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr   = take && WB_WE_I;

    // ------------------------------------------------------------------
    // Bus and pin relations
    // ------------------------------------------------------------------
    a_ack_follows: assert property (take |=> WB_ACK_O) else $error("ack missing after request");
    a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(take)) else $error("ack without request");
    a_data_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("read data outside ack");
    a_data_byte: assert property (WB_DAT_O[31:8] == 24'h0) else $error("read data upper bits set");
    a_reset_quiet: assert property (disable iff (1'b0) !RST_N_I |=>
        {WAVE_A_PIN_O, WAVE_A_OE_O, WAVE_B_PIN_O, WAVE_B_OE_O, WB_ACK_O} == 5'h0)
        else $error("outputs active in reset");
    a_oe_cause: assert property ($changed({WAVE_B_OE_O, WAVE_A_OE_O}) |->
        $past(wr) || $past(wr, 2)) else $error("pin enable moved without write");
    // A pin may only move after a timer tick or a register write
    a_pin_cause: assert property ($changed({WAVE_B_PIN_O, WAVE_A_PIN_O}) |->
        $past(TIMER_TICK_I) || $past(wr) || $past(wr, 2)) else $error("pin moved without cause");

    c_write: cover property (wr);
    c_rise_a: cover property ($rose(WAVE_A_PIN_O) && WAVE_A_OE_O);
    c_fall_b: cover property ($fell(WAVE_B_PIN_O));
endmodule : tw_timer_top_chk

bind tw_timer_top tw_timer_top_chk tw_timer_top_chk_i (
    .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .TIMER_TICK_I(TIMER_TICK_I),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .WAVE_A_PIN_O(WAVE_A_PIN_O), .WAVE_A_OE_O(WAVE_A_OE_O),
    .WAVE_B_PIN_O(WAVE_B_PIN_O), .WAVE_B_OE_O(WAVE_B_OE_O));

// ### tw_pad_model.sv
`timescale 1ns/1ps
module tw_pad_model (
    // From the block
    input  wire logic drv_i,
    input  wire logic oe_i,
    // Pad level
    output logic      pad_o
);
    // Undriven pad floats up through the port pull-up
    assign pad_o = oe_i ? drv_i : 1'b1;
endmodule : tw_pad_model

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top
    import tw_pkg::*;
;
    logic                clk;
    logic                rst_n;
    logic                tick;
    logic                cyc;
    logic                stb;
    logic                we;
    logic [TW_ADR_W-1:0] adr;
    logic [3:0]          sel;
    logic [31:0]         dat_w;
    logic [31:0]         dat_r;
    logic                ack;
    logic                pin_a;
    logic                oe_a;
    logic                pin_b;
    logic                oe_b;
    logic                pad_a;
    logic                pad_b;
    int                  n_mismatch = 0;
    int                  checked = 0;
    int                  cyc_cnt = 0;
    logic [7:0]          q;
    logic                e;

    tw_timer_top tw_timer_top_i (.REF_CLK_I(clk), .RST_N_I(rst_n), .TIMER_TICK_I(tick),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack), .WAVE_A_PIN_O(pin_a),
        .WAVE_A_OE_O(oe_a), .WAVE_B_PIN_O(pin_b), .WAVE_B_OE_O(oe_b));
    tw_pad_model tw_pad_model_a_i (.drv_i(pin_a), .oe_i(oe_a), .pad_o(pad_a));
    tw_pad_model tw_pad_model_b_i (.drv_i(pin_b), .oe_i(oe_b), .pad_o(pad_b));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task complete_run;
        if (n_mismatch == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // Request held until the edge that samples ack, then released
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, dat_w} <= {1'b1, 1'b1, w, a, 24'h0, d};
        // Ack and read data are judged at the rising edge that samples them
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat_r[7:0];
        if (n >= 20) chk(8'h1, 8'h0, "bus timeout");
        {cyc, stb, we} <= 3'h0;
    endtask : wb

    task wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] exp, input string m);
        wb(1'b0, a, 8'h0);
        chk(q, exp, m);
    endtask : rd

    task tk(input int n);
        repeat (n) begin
            @(posedge clk);
            tick <= 1'b1;
        end
        @(posedge clk);
        tick <= 1'b0;
    endtask : tk

    task pins(input logic [1:0] exp, input string m);
        @(negedge clk);
        chk({6'h0, pad_b, pad_a}, {6'h0, exp}, m);
    endtask : pins

    function automatic logic [7:0] ctl(input logic [2:0] md, input logic [1:0] ca, input logic [1:0] cb);
        return {ca, cb, 1'b0, md};
    endfunction : ctl

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_reset;
        rd(TW_OFS_CTRL, 8'h0, "ctrl");
        rd(TW_OFS_PORT, 8'h0, "wave state");
        wr(8'h18, 8'h5a);
        rd(8'h18, 8'h0, "unmapped");
        chk({6'h0, oe_b, oe_a}, 8'h0, "oe");
    endtask : t_reset

    task t_normal;
        wr(TW_OFS_PORT, 8'h03);
        wr(TW_OFS_CTRL, ctl(3'h0, TW_COM_SET, TW_COM_OFF));
        wr(TW_OFS_CMP_A, 8'h05);
        wr(TW_OFS_COUNT, 8'h04);
        wr(TW_OFS_FLAGS, 8'h07);
        tk(2);
        rd(TW_OFS_FLAGS, 8'h02, "match a");
        pins(2'b01, "set on match");
        wr(TW_OFS_COUNT, 8'hfe);
        wr(TW_OFS_FLAGS, 8'h07);
        tk(1);
        rd(TW_OFS_FLAGS, 8'h00, "no ovf");
        tk(1);
        rd(TW_OFS_FLAGS, 8'h01, "ovf");
        tk(3);
        rd(TW_OFS_COUNT, 8'h03, "wrap");
        // Compare B stays at zero, so passing zero also raises its match flag
        rd(TW_OFS_FLAGS, 8'h05, "ovf kept");
    endtask : t_normal

    task t_ctc;
        wr(TW_OFS_CTRL, ctl(TW_SEL_CTC, TW_COM_TOGGLE, TW_COM_OFF));
        wr(TW_OFS_CMP_A, 8'h03);
        wr(TW_OFS_COUNT, 8'h00);
        wr(TW_OFS_FLAGS, 8'h07);
        tk(4);
        rd(TW_OFS_COUNT, 8'h00, "ctc clear");
        rd(TW_OFS_FLAGS, 8'h02, "ctc flag");
        pins(2'b00, "ctc toggle");
        tk(4);
        pins(2'b01, "ctc toggle back");
        wr(TW_OFS_COUNT, 8'h05);
        wr(TW_OFS_CMP_A, 8'h02);
        wr(TW_OFS_FLAGS, 8'h07);
        tk(250);
        rd(TW_OFS_COUNT, 8'hff, "missed top");
        tk(1);
        rd(TW_OFS_FLAGS, 8'h01, "ctc ovf");
        tk(3);
        rd(TW_OFS_COUNT, 8'h00, "late match");
        wr(TW_OFS_CMP_A, 8'h00);
        e = 1'b0;
        repeat (2) begin
            e = ~e;
            tk(1);
            pins({1'b0, e}, "half rate");
        end
    endtask : t_ctc

    task t_fast;
        wr(TW_OFS_CMP_A, 8'h10);
        wr(TW_OFS_CMP_B, 8'h10);
        wr(TW_OFS_CTRL, ctl(TW_SEL_FAST_MAX, TW_COM_CLEAR, TW_COM_SET));
        wr(TW_OFS_PORT, 8'h03);
        wr(TW_OFS_COUNT, 8'hfe);
        wr(TW_OFS_FLAGS, 8'h07);
        tk(2);
        rd(TW_OFS_COUNT, 8'h00, "fast wrap");
        rd(TW_OFS_FLAGS, 8'h01, "fast ovf");
        pins(2'b01, "bottom levels");
        tk(17);
        pins(2'b10, "match levels");
        wr(TW_OFS_CMP_A, 8'h20);
        rd(TW_OFS_CMP_A, 8'h20, "buffer readback");
        tk(256);
        pins(2'b11, "new compare at wrap");
        wr(TW_OFS_CTRL, ctl(3'h0, TW_COM_OFF, TW_COM_OFF));
        wr(TW_OFS_CMP_A, 8'h03);
        wr(TW_OFS_CMP_B, 8'h02);
        wr(TW_OFS_CTRL, ctl(TW_SEL_FAST_CMP, TW_COM_TOGGLE, TW_COM_TOGGLE));
        wr(TW_OFS_COUNT, 8'h00);
        tk(4);
        rd(TW_OFS_COUNT, 8'h00, "top from a");
        pins(2'b10, "toggle a only");
        tk(4);
        pins(2'b11, "even duty");
    endtask : t_fast

    task t_phase;
        wr(TW_OFS_CTRL, ctl(3'h0, TW_COM_OFF, TW_COM_OFF));
        wr(TW_OFS_CMP_A, 8'h80);
        wr(TW_OFS_CMP_B, 8'h80);
        wr(TW_OFS_CTRL, ctl(TW_SEL_PC_MAX, TW_COM_CLEAR, TW_COM_SET));
        wr(TW_OFS_COUNT, 8'h7f);
        tk(2);
        pins(2'b10, "up match");
        tk(8'h7e);
        rd(TW_OFS_COUNT, 8'hff, "at top");
        tk(1);
        rd(TW_OFS_COUNT, 8'hfe, "top once");
        tk(8'h7f);
        pins(2'b01, "down match");
        wr(TW_OFS_FLAGS, 8'h07);
        tk(8'h7f);
        rd(TW_OFS_FLAGS, 8'h01, "bottom ovf");
        wr(TW_OFS_CTRL, ctl(3'h0, TW_COM_OFF, TW_COM_OFF));
        wr(TW_OFS_CMP_A, 8'h04);
        wr(TW_OFS_CTRL, ctl(TW_SEL_PC_CMP, TW_COM_OFF, TW_COM_OFF));
        wr(TW_OFS_COUNT, 8'h00);
        tk(5);
        rd(TW_OFS_COUNT, 8'h03, "top from a");
        wr(TW_OFS_PORT, 8'h01);
        pins(2'b10, "port data, b floats");
    endtask : t_phase

    // ------------------------------------------------------------------
    // Clock, reset, run
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        {rst_n, tick, cyc, stb, we, adr, dat_w} = '0;
        sel = 4'h1;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_normal();
        t_ctc();
        t_fast();
        t_phase();
        complete_run();
    end
endmodule : tb_top
